// File: bench/analog_source.sv
// Analog input model: compares a held input level with the trial word.
module analog_source
    import adc_pkg::*;
(
    input  wire adc_pkg::result_t level_in,
    input  wire adc_pkg::result_t trial_in,
    output logic                  comparator_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // A level at or above the trial keeps that bit, so the settled word equals the level.
    assign comparator_out = (level_in >= trial_in);
endmodule : analog_source

// File: bench/sar_adc_parallel_read_control_properties.sv
// Concurrent checks on the ports of the converter control top.
module sar_adc_parallel_read_control_properties
    import adc_pkg::*;
#(
    parameter int RESULT_BITS = 12,
    parameter int FIFO_WORDS  = 16,
    parameter int BIT_CYCLES  = 22
) (
    input wire logic             clk_in,
    input wire logic             rst_in,
    input wire logic             ce_in,
    input wire logic             select_n_in,
    input wire logic             read_n_in,
    input wire logic             high_byte_select_in,
    input wire logic             bipolar_in,
    input wire logic             comparator_in,
    input wire logic             busy_n_out,
    input wire adc_pkg::result_t result_output_lines_out,
    input wire logic             result_output_oe_out,
    input wire adc_pkg::result_t dac_trial_out
);
    // ======================================================================
    // Helper logic
    // ======================================================================
    logic term;
    logic term_q;

    assign term = !select_n_in && !read_n_in && !high_byte_select_in;

    // Starts are taken on the edge of the term, so the previous value is kept.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            term_q <= 1'b0;
        end else if (ce_in) begin
            term_q <= term;
        end
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ======================================================================
    // Assertions
    // ======================================================================
    start_all_low_a: assert property (
        busy_n_out && ce_in && term && !term_q |=> !busy_n_out)
        else $error("no conversion start on select, read and byte select low");
    start_blocked_a: assert property (
        busy_n_out && ce_in && !term |=> busy_n_out)
        else $error("conversion started with a control input high");
    busy_span_a: assert property (
        $fell(busy_n_out) |-> !busy_n_out [*8] ##[1:300] busy_n_out)
        else $error("busy low time outside its bounds");
    trial_cleared_a: assert property (
        $fell(busy_n_out) |-> dac_trial_out == 12'h800)
        else $error("trial word not cleared to the top bit at start");
    high_byte_lines_a: assert property (
        result_output_oe_out && $past(high_byte_select_in) |->
            result_output_lines_out[7:4] == 4'h0 &&
            result_output_lines_out[3:0] == result_output_lines_out[11:8])
        else $error("upper byte read has wrong line layout");
    lines_float_a: assert property (
        ce_in && (select_n_in || read_n_in) |=> !result_output_oe_out)
        else $error("data lines driven without select and read");
    lines_drive_a: assert property (
        ce_in && !select_n_in && !read_n_in |=> result_output_oe_out)
        else $error("data lines not driven during a read");
    held_no_restart_a: assert property (
        $rose(busy_n_out) && term && term_q |=> busy_n_out)
        else $error("held read restarted a conversion");
endmodule : sar_adc_parallel_read_control_properties

bind sar_adc_parallel_read_control sar_adc_parallel_read_control_properties #(
    .RESULT_BITS(RESULT_BITS),
    .FIFO_WORDS (FIFO_WORDS),
    .BIT_CYCLES (BIT_CYCLES)
) chk_u (
    .clk_in                 (clk_in),
    .rst_in                 (rst_in),
    .ce_in                  (ce_in),
    .select_n_in            (select_n_in),
    .read_n_in              (read_n_in),
    .high_byte_select_in    (high_byte_select_in),
    .bipolar_in             (bipolar_in),
    .comparator_in          (comparator_in),
    .busy_n_out             (busy_n_out),
    .result_output_lines_out(result_output_lines_out),
    .result_output_oe_out   (result_output_oe_out),
    .dac_trial_out          (dac_trial_out)
);

// File: bench/test_sar_adc_parallel_read_control.sv
// Self-checking bench for the converter control with a model of expected results.
module test_sar_adc_parallel_read_control
    import adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // Signals and model state
    // ======================================================================
    localparam int BITC = 2;
    // Twelve decisions, then push, buffer write, latch load and busy release.
    localparam int SPAN = 12 * BITC + 4;
    logic    clk = 1'b0, rst = 1'b1, ce = 1'b1, sel_n = 1'b1, rd_n = 1'b1, hbs = 1'b0;
    logic    bip = 1'b0, cmp, busy_n, oe;
    result_t level = 12'h000, lines, trial;
    result_t model_q[$] = '{12'h000};
    int      mismatches = 0, compares = 0, seed = 32'h5dc0, low_cycles, cyc = 0, t0;
    int      ce_gap = 0;
    result_t codes[6] = '{12'h000, 12'hfff, 12'h7ff, 12'h800, 12'h001, 12'hffe};

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    sar_adc_parallel_read_control #(.BIT_CYCLES(BITC)) dut_u (
        .clk_in(clk), .rst_in(rst), .ce_in(ce), .select_n_in(sel_n), .read_n_in(rd_n),
        .high_byte_select_in(hbs), .bipolar_in(bip), .comparator_in(cmp),
        .busy_n_out(busy_n), .result_output_lines_out(lines), .result_output_oe_out(oe),
        .dac_trial_out(trial));
    analog_source src_u (.level_in(level), .trial_in(trial), .comparator_out(cmp));

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic check(input string what, input result_t exp, input result_t got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic bus(input logic s, input logic r, input logic h);
        @(posedge clk);
        sel_n <= s;
        rd_n  <= r;
        hbs   <= h;
    endtask : bus

    task automatic wait_busy(input logic lvl);
        low_cycles = 0;
        while (busy_n !== lvl && low_cycles < 200) begin
            @(negedge clk);
            low_cycles++;
        end
        check("busy_n", {11'h0, lvl}, {11'h0, busy_n});
    endtask : wait_busy

    // Mode 0 releases at once, 1 holds the read, 2 releases and asserts again.
    task automatic convert(input result_t lvl, input logic b, input int mode);
        result_t exp;
        int      span;
        exp = b ? (lvl ^ 12'h800) : lvl;
        @(posedge clk);
        level <= lvl;
        bip   <= b;
        sel_n <= 1'b0;
        rd_n  <= 1'b0;
        hbs   <= 1'b0;
        wait_busy(1'b0);
        t0 = cyc;
        check("old result", model_q[$], lines);
        check("oe", 12'h001, {11'h0, oe});
        if (mode != 1) bus(1'b1, 1'b1, 1'b0);
        if (mode == 2) begin
            repeat (5) @(posedge clk);
            bus(1'b0, 1'b0, 1'b0);
        end
        if (mode == 0 && ce_gap > 0) begin
            // Each frozen cycle stretches the conversion by one.
            @(posedge clk);
            ce <= 1'b0;
            repeat (ce_gap) @(posedge clk);
            ce <= 1'b1;
        end
        span = (mode == 0) ? SPAN + ce_gap : SPAN;
        wait_busy(1'b1);
        check("busy span", result_t'(span), result_t'(cyc - t0));
        if (mode != 0) check("new result", exp, lines);
        bus(1'b1, 1'b1, 1'b0);
        @(negedge clk);
        @(negedge clk);
        check("oe", 12'h000, {11'h0, oe});
        model_q.push_back(exp);
        repeat (57) @(posedge clk);
    endtask : convert

    task automatic read_high();
        bus(1'b0, 1'b0, 1'b1);
        repeat (4) @(negedge clk);
        check("upper byte", {model_q[$][11:8], 4'h0, model_q[$][11:8]}, lines);
        check("busy_n", 12'h001, {11'h0, busy_n});
        bus(1'b1, 1'b1, 1'b0);
    endtask : read_high

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ======================================================================
    // Sequence
    // ======================================================================
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("busy_n", 12'h001, {11'h0, busy_n});
        check("oe", 12'h000, {11'h0, oe});
        convert(12'h5a3, 1'b0, 1);
        for (int b = 0; b < 2; b++) begin
            foreach (codes[i]) begin
                convert(codes[i], b[0], i % 3);
                read_high();
            end
        end
        for (int k = 0; k < 2; k++) begin
            bus(k[0], !k[0], 1'b0);
            repeat (4) @(negedge clk);
            check("busy_n", 12'h001, {11'h0, busy_n});
            bus(1'b1, 1'b1, 1'b0);
        end
        repeat (8) begin
            ce_gap = $random(seed) & 7;
            convert(result_t'($random(seed)), 1'($random(seed) & 1), ($random(seed) & 255) % 3);
            read_high();
        end
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule : test_sar_adc_parallel_read_control

// File: rtl/adc_params.svh
// Timing counts, widths, reset values and output field positions of the converter control.
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// ==========================================================================
// Clock and conversion timing
// ==========================================================================
`define CLK_PERIOD_NS     20
`define CONV_TYP_NS       5500
`define CONV_MAX_NS       6000
// Typical time rounds up, longest time rounds down.
`define CONV_TYP_CYCLES   ((`CONV_TYP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_MAX_CYCLES   (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define CONV_OVERHEAD     3

// ==========================================================================
// Widths and depths
// ==========================================================================
`define RESULT_BITS       12
`define FIFO_WORDS        16
`define BIT_CYCLES        (`CONV_TYP_CYCLES / `RESULT_BITS)

// ==========================================================================
// Output line fields
// ==========================================================================
`define TOP_NIBBLE_MSB    11
`define TOP_NIBBLE_LSB    8
`define MID_NIBBLE_MSB    7
`define MID_NIBBLE_LSB    4
`define LOW_NIBBLE_MSB    3
`define LOW_NIBBLE_LSB    0

// ==========================================================================
// Reset values and start trial
// ==========================================================================
`define RESULT_RESET      12'h000
`define BUSY_N_RESET      1'b1
`define MSB_TRIAL         12'h800

`endif

// File: rtl/adc_pkg.sv
// Types shared by the converter control modules.
package adc_pkg;

    // ======================================================================
    // Types
    // ======================================================================
    typedef logic [11:0] result_t;

    // Gray coded along idle, convert, push, latch.
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_CONVERT = 2'b01,
        ST_PUSH    = 2'b11,
        ST_LATCH   = 2'b10
    } ctrl_state_e;

endpackage : adc_pkg

// File: rtl/result_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
module result_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = $clog2(DEPTH);

    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
    } fifo_s;

    fifo_s q;
    fifo_s d;
    logic  full;
    logic  empty;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_depth_check
        $error("result_fifo: DEPTH must be a power of two of at least 2");
    end

    // Pointers carry one extra bit so full and empty are told apart honestly.
    assign full  = (q.wr_ptr[AW] != q.rd_ptr[AW]) && (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]);
    assign empty = (q.wr_ptr == q.rd_ptr);

    always_comb begin
        d = q;
        if (ce_in) begin
            if (in_valid_in && !full) begin
                d.mem[q.wr_ptr[AW-1:0]] = in_data_in;
                d.wr_ptr = q.wr_ptr + 1'b1;
            end
            if (out_ready_in && !empty) begin
                d.rd_ptr = q.rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign in_ready_out  = !full;
    assign out_valid_out = !empty;
    assign out_data_out  = q.mem[q.rd_ptr[AW-1:0]];

endmodule : result_fifo

// File: rtl/sar_adc_parallel_read_control.sv
// Conversion control and parallel read interface of a 12-bit successive-approximation converter.
`include "adc_params.svh"

module sar_adc_parallel_read_control #(
    parameter int RESULT_BITS = `RESULT_BITS,
    parameter int FIFO_WORDS  = `FIFO_WORDS,
    parameter int BIT_CYCLES  = `BIT_CYCLES
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             select_n_in,
    input  wire logic             read_n_in,
    input  wire logic             high_byte_select_in,
    input  wire logic             bipolar_in,
    input  wire logic             comparator_in,
    output logic                  busy_n_out,
    output adc_pkg::result_t      result_output_lines_out,
    output logic                  result_output_oe_out,
    output adc_pkg::result_t      dac_trial_out
);
    import adc_pkg::*;

    // ======================================================================
    // Elaboration checks
    // ======================================================================
    if (RESULT_BITS != 12) begin : g_width_check
        $error("sar_adc_parallel_read_control: only 12 result bits are supported");
    end
    if (RESULT_BITS * BIT_CYCLES + `CONV_OVERHEAD > `CONV_MAX_CYCLES) begin : g_time_check
        $error("sar_adc_parallel_read_control: conversion would exceed its longest time");
    end

    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed {
        ctrl_state_e state;
        logic        start_seen;
        logic        busy_n;
        result_t     pending;
        result_t     out_latch;
        result_t     lines;
        logic        oe;
    } ctrl_s;

    ctrl_s q;
    ctrl_s d;

    sar_link_if link ();

    logic    fifo_in_valid;
    logic    fifo_in_ready;
    logic    fifo_out_valid;
    logic    fifo_out_ready;
    result_t fifo_out_data;
    logic    start_term;
    logic    read_term;
    result_t coded;

    // ======================================================================
    // Decode of the control inputs
    // ======================================================================
    // All three inputs must be low; a high byte select blocks the start.
    assign start_term = !select_n_in && !read_n_in && !high_byte_select_in;
    assign read_term  = !select_n_in && !read_n_in;

    // Offset binary from the engine becomes two's complement by flipping the MSB.
    assign coded = bipolar_in ? {~link.trial[11], link.trial[10:0]} : link.trial;

    // ======================================================================
    // Approximation engine and result buffer
    // ======================================================================
    assign link.comparator = comparator_in;
    assign link.start      = ce_in && (q.state == ST_IDLE) && start_term && !q.start_seen;

    sar_engine #(
        .BIT_CYCLES (BIT_CYCLES)
    ) u_engine (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .ce_in  (ce_in),
        .link   (link)
    );

    assign fifo_in_valid = (q.state == ST_PUSH);
    // The latch refuses a new word while a high-byte read is on the bus, so the two
    // bytes of one result never tear; the buffer absorbs the finished word meanwhile.
    assign fifo_out_ready = !(read_term && high_byte_select_in);

    result_fifo #(
        .WIDTH (RESULT_BITS),
        .DEPTH (FIFO_WORDS)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .ce_in         (ce_in),
        .in_valid_in   (fifo_in_valid),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (q.pending),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (fifo_out_ready),
        .out_data_out  (fifo_out_data)
    );

    // ======================================================================
    // Control sequence
    // ======================================================================
    always_comb begin
        d = q;
        if (ce_in) begin
            // The start is edge based so a read held for the whole conversion
            // cannot trigger a second one when the first ends.
            d.start_seen = start_term;
            if (fifo_out_valid && fifo_out_ready) begin
                d.out_latch = fifo_out_data;
            end
            case (q.state)
                ST_IDLE: begin
                    d.busy_n = 1'b1;
                    if (link.start) begin
                        d.state  = ST_CONVERT;
                        d.busy_n = 1'b0;
                    end
                end
                ST_CONVERT: begin
                    // Further start conditions are not looked at here.
                    if (link.done) begin
                        d.pending = coded;
                        d.state   = ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    // A full buffer holds busy low until room appears.
                    if (fifo_in_ready) begin
                        d.state = ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    if (fifo_out_valid && fifo_out_ready) begin
                        d.state = ST_IDLE;
                    end
                end
                default: begin
                    d.state  = ST_IDLE;
                    d.busy_n = 1'b1;
                end
            endcase

            // Output drivers follow select and read strobe only.
            d.oe = read_term;
            if (high_byte_select_in) begin
                d.lines = {q.out_latch[`TOP_NIBBLE_MSB:`TOP_NIBBLE_LSB], 4'h0,
                           q.out_latch[`TOP_NIBBLE_MSB:`TOP_NIBBLE_LSB]};
            end else begin
                d.lines = q.out_latch;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q           <= '0;
            q.state     <= ST_IDLE;
            q.busy_n    <= `BUSY_N_RESET;
            q.out_latch <= `RESULT_RESET;
            q.lines     <= `RESULT_RESET;
        end else begin
            q <= d;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign busy_n_out              = q.busy_n;
    assign result_output_lines_out = q.lines;
    assign result_output_oe_out    = q.oe;
    assign dac_trial_out           = link.trial;

endmodule : sar_adc_parallel_read_control

// File: rtl/sar_engine.sv
// Successive-approximation engine: walks the trial word from MSB to LSB.
`include "adc_params.svh"

module sar_engine #(
    parameter int BIT_CYCLES = `BIT_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    sar_link_if.engine link
);
    import adc_pkg::*;

    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed {
        logic       active;
        logic [3:0] bit_idx;
        logic [7:0] tick;
        result_t    approx;
        logic       done;
    } engine_s;

    engine_s q;
    engine_s d;

    if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin : g_cycles_check
        $error("sar_engine: BIT_CYCLES out of range");
    end

    always_comb begin
        d = q;
        if (ce_in) begin
            // The done pulse only ends on an enabled cycle; clearing it while the enable
            // is low would lose it before the frozen control side could see it.
            d.done = 1'b0;
            if (!q.active) begin
                if (link.start) begin
                    // Clearing the register and setting the MSB trial in one step.
                    d.active  = 1'b1;
                    d.approx  = `MSB_TRIAL;
                    d.bit_idx = 4'd11;
                    d.tick    = 8'd0;
                end
            end else if (q.tick == 8'(BIT_CYCLES - 1)) begin
                d.tick = 8'd0;
                if (!link.comparator) begin
                    d.approx[q.bit_idx] = 1'b0;
                end
                if (q.bit_idx == 4'd0) begin
                    d.active = 1'b0;
                    d.done   = 1'b1;
                end else begin
                    d.approx[q.bit_idx - 4'd1] = 1'b1;
                    d.bit_idx = q.bit_idx - 4'd1;
                end
            end else begin
                d.tick = q.tick + 8'd1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign link.trial = q.approx;
    assign link.done  = q.done;

endmodule : sar_engine

// File: rtl/sar_link_if.sv
// Carrier between the control top and the approximation register engine.
interface sar_link_if;
    import adc_pkg::*;

    logic    start;
    logic    done;
    logic    comparator;
    result_t trial;

    modport ctrl (output start, output comparator, input done, input trial);
    modport engine (input start, input comparator, output done, output trial);

endinterface : sar_link_if
